// ---- tbd_decoder.sv ----
// twelve bit instruction decoder with instruction cycle sequencing
// assumes program memory holds i_instr stable through each cycle
`timescale 1ns/1ps
`include "tbd_params.svh"

// Functional notes
// - word is opcode plus operand fields
// - classify byte, bit or literal/control
// - file select picks one of 32
// - destination 0 accumulator, 1 file
// - bit select names bit in file
// - literal is 8 or 9 bits
// - don't-care bits ignored in decode
// - branches or true skips take two cycles
// - instruction cycle is four clocks
// - byte format opcode, d, file
// - bit format opcode, bit, file
// - literal format opcode, 8-bit immediate
// - branch format opcode, 9-bit target
module tbd_decoder
   import tbd_pkg::*;
#(
   parameter int WORD_W = `TBD_WORD_W
) (
   // clock and reset
   input  wire logic              i_ref_clk,
   input  wire logic              i_arst_n,
   // instruction and condition
   input  wire logic [WORD_W-1:0] i_instr,
   input  wire logic              i_skip_true,
   // decode results
   output tbd_decode_type         o_dec,
   output logic                   o_fetch,
   output logic                   o_second_cycle,
   output logic [1:0]             o_phase
);
   // raw fields of the word
   logic [1:0]     class_bits;
   logic [2:0]     top3_op;
   logic [5:0]     byte_op;
   logic [3:0]     bit_op;
   logic [3:0]     lit_op;
   logic           dest_field;
   logic [4:0]     file_field;
   logic [2:0]     bit_field;
   logic [7:0]     lit8_field;
   logic [8:0]     lit9_field;

   // instruction kinds
   logic           is_byte;
   logic           is_bit;
   logic           is_jump;
   logic           is_call;
   logic           is_ret;
   logic           is_bit_test;
   logic           is_fsz;

   // per class decodes
   tbd_decode_type byte_dec;
   tbd_decode_type bit_dec;
   tbd_decode_type lit_dec;
   tbd_decode_type word_dec;

   // sequencing and registers
   logic [1:0]     phase;
   logic           cyc_end;
   tbd_decode_type dec_d;
   tbd_decode_type dec_q;
   logic           two_needed;
   logic           load_slot;
   logic           second_d;
   logic           second_q;
   logic           fetch_d;
   logic           fetch_q;
   logic [1:0]     phase_d;
   logic [1:0]     phase_q;

   tbd_phase_seq u_seq (
      .i_ref_clk   (i_ref_clk),
      .i_arst_n    (i_arst_n),
      .o_phase     (phase),
      .o_cycle_end (cyc_end)
   );

   always_comb begin
      class_bits = i_instr[`TBD_CLASS_HI:`TBD_CLASS_LO];
      top3_op    = i_instr[`TBD_JMP_OP_HI:`TBD_JMP_OP_LO];
      byte_op    = i_instr[`TBD_BYTE_OP_HI:`TBD_BYTE_OP_LO];
      bit_op     = i_instr[`TBD_BIT_OP_HI:`TBD_BIT_OP_LO];
      lit_op     = i_instr[`TBD_LIT_OP_HI:`TBD_LIT_OP_LO];
      dest_field = i_instr[`TBD_DEST_POS];
      file_field = i_instr[`TBD_FILE_HI:0];
      bit_field  = i_instr[`TBD_BITNUM_HI:`TBD_BITNUM_LO];
      lit8_field = i_instr[`TBD_LIT8_HI:0];
      lit9_field = i_instr[`TBD_LIT9_HI:0];
   end

   always_comb begin
      is_byte = (class_bits == `TBD_BYTE_CLS);
      is_bit  = (class_bits == `TBD_BIT_CLS);
   end

   always_comb begin
      is_jump     = (top3_op == `TBD_JMP_CODE);
      is_call     = (lit_op == `TBD_CALL_CODE);
      is_ret      = (lit_op == `TBD_RET_CODE);
      is_bit_test = (top3_op == `TBD_BITTEST_HI);
      is_fsz      = (top3_op == `TBD_FSZ_CODE)
                 && (byte_op[1:0] == `TBD_FSZ_TAIL);
   end

   always_comb begin
      byte_dec           = '0;
      byte_dec.class_sel = TBD_CLS_BYTE;
      byte_dec.opcode    = byte_op;
      byte_dec.dest_file = dest_field;
      byte_dec.file_sel  = file_field;
   end

   always_comb begin
      bit_dec           = '0;
      bit_dec.class_sel = TBD_CLS_BIT;
      bit_dec.opcode    = {2'h0, bit_op};
      bit_dec.bit_sel   = bit_field;
      bit_dec.file_sel  = file_field;
   end

   always_comb begin
      lit_dec           = '0;
      lit_dec.class_sel = TBD_CLS_LIT;
      lit_dec.lit_is_9  = is_jump;
      // literal words select no file
      lit_dec.file_sel  = 5'h0;
      if (is_jump) begin
         lit_dec.opcode  = {3'h0, top3_op};
         lit_dec.literal = lit9_field;
      end else begin
         lit_dec.opcode  = {2'h0, lit_op};
         lit_dec.literal = {1'b0, lit8_field};
      end
   end

   always_comb begin
      if (is_byte) begin
         word_dec = byte_dec;
      end else if (is_bit) begin
         word_dec = bit_dec;
      end else begin
         word_dec = lit_dec;
      end
      word_dec.cond_skip = is_bit_test || (is_byte && is_fsz);
      word_dec.two_cycle = is_jump || is_call || is_ret;
   end

   // decoded word held between loads
   always_comb begin
      dec_d = dec_q;
      if (fetch_d) begin
         dec_d = word_dec;
      end
   end

   always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         dec_q <= '0;
      end else begin
         dec_q <= dec_d;
      end
   end

   // second cycle after branch or skip
   always_comb begin
      two_needed = dec_q.two_cycle || (dec_q.cond_skip && i_skip_true);
      second_d   = second_q;
      if (cyc_end) begin
         second_d = !second_q && two_needed;
      end
      load_slot = (phase == 2'(`TBD_OSC_PER_CYC - 1));
      fetch_d   = load_slot && !second_d;
   end

   always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         second_q <= 1'b0;
         fetch_q  <= 1'b0;
      end else begin
         second_q <= second_d;
         fetch_q  <= fetch_d;
      end
   end

   // phase shown one clock late
   always_comb begin
      phase_d = phase;
   end

   always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         phase_q <= 2'h0;
      end else begin
         phase_q <= phase_d;
      end
   end

   assign o_dec          = dec_q;
   assign o_fetch        = fetch_q;
   assign o_second_cycle = second_q;
   assign o_phase        = phase_q;
endmodule

// ---- tbd_params.svh ----
// timing and field constants for the twelve bit instruction decoder
// assumes inclusion by bare name from the package and modules
`ifndef TBD_PARAMS_SVH
`define TBD_PARAMS_SVH
`define TBD_WORD_W        12
`define TBD_OSC_PER_CYC   4
`define TBD_FILE_W        5
`define TBD_BYTE_OP_HI    11
`define TBD_BYTE_OP_LO    6
`define TBD_DEST_POS      5
`define TBD_FILE_HI       4
`define TBD_BIT_OP_HI     11
`define TBD_BIT_OP_LO     8
`define TBD_BITNUM_HI     7
`define TBD_BITNUM_LO     5
`define TBD_LIT_OP_HI     11
`define TBD_LIT_OP_LO     8
`define TBD_LIT8_HI       7
`define TBD_JMP_OP_HI     11
`define TBD_JMP_OP_LO     9
`define TBD_LIT9_HI       8
`define TBD_JMP_CODE      3'h5
`define TBD_CALL_CODE     4'h9
`define TBD_RET_CODE      4'h8
`define TBD_BITTEST_HI    3'h3
`define TBD_CLASS_HI      11
`define TBD_CLASS_LO      10
`define TBD_BYTE_CLS      2'h0
`define TBD_BIT_CLS       2'h1
`define TBD_FSZ_CODE      3'h1
`define TBD_FSZ_TAIL      2'h3
`endif

// ---- tbd_pkg.sv ----
// types shared by the instruction decoder and its sequencer
// assumes tbd_params.svh is on the include path
`include "tbd_params.svh"
package tbd_pkg;
   typedef enum logic [1:0] {
      TBD_CLS_BYTE,
      TBD_CLS_BIT,
      TBD_CLS_LIT
   } tbd_class_type;

   typedef struct packed {
      tbd_class_type class_sel;
      logic [5:0]    opcode;
      logic          dest_file;
      logic [4:0]    file_sel;
      logic [2:0]    bit_sel;
      logic [8:0]    literal;
      logic          lit_is_9;
      logic          two_cycle;
      logic          cond_skip;
   } tbd_decode_type;
endpackage

// ---- tbd_phase_seq.sv ----
// four phase sequencer forming one instruction cycle
// assumes a free running core clock
`timescale 1ns/1ps
`include "tbd_params.svh"
module tbd_phase_seq
   import tbd_pkg::*;
#(
   parameter int PHASES = `TBD_OSC_PER_CYC
) (
   // clock and reset
   input  wire logic       i_ref_clk,
   input  wire logic       i_arst_n,
   // phase outputs
   output logic [1:0]      o_phase,
   output logic            o_cycle_end
);
   logic [1:0] phase_q;
   logic [1:0] phase_d;
   logic       end_q;
   logic       end_d;

   always_comb begin
      end_d   = (phase_q == 2'(PHASES - 2));
      phase_d = (phase_q == 2'(PHASES - 1)) ? 2'h0 : phase_q + 2'h1;
   end

   always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         phase_q <= 2'h0;
         end_q   <= 1'b0;
      end else begin
         phase_q <= phase_d;
         end_q   <= end_d;
      end
   end

   assign o_phase     = phase_q;
   assign o_cycle_end = end_q;
endmodule

// ---- tbd_decoder_sva.sv ----
// assertions on the decoder ports
// assumes a bind from the bench top
`timescale 1ns/1ps
module tbd_decoder_sva
   import tbd_pkg::*;
(
   input wire logic           i_ref_clk,
   input wire logic           i_arst_n,
   input wire logic [11:0]    i_instr,
   input wire logic           i_skip_true,
   input wire tbd_decode_type o_dec,
   input wire logic           o_fetch,
   input wire logic           o_second_cycle,
   input wire logic [1:0]     o_phase
);
   logic [11:0] w_q;
   default clocking @(posedge i_ref_clk); endclocking
   default disable iff (!i_arst_n);
   always_ff @(posedge i_ref_clk) w_q <= i_instr;
   a_fetch_dec_hold: assert property (
      o_fetch |=> (!o_fetch && $stable(o_dec)) [*3]) else $error("hold");
   a_second_no_fetch: assert property (
      o_second_cycle |-> !o_fetch) else $error("fetch in second");
   a_two_second: assert property (
      o_fetch && o_dec.two_cycle |-> ##[1:8] o_second_cycle) else $error("2c");
   a_two_gap_eight: assert property (
      o_fetch && o_dec.two_cycle |-> ##8 o_fetch) else $error("gap8");
   a_one_gap_four: assert property (
      o_fetch && !o_dec.two_cycle && !o_dec.cond_skip |-> ##4 o_fetch)
      else $error("gap4");
   a_file_sel_map: assert property (
      o_fetch |-> o_dec.file_sel == (w_q[11] ? 5'h0 : w_q[4:0]))
      else $error("file");
   a_dest_sel_map: assert property (
      o_fetch && o_dec.class_sel == TBD_CLS_BYTE |-> o_dec.dest_file == w_q[5])
      else $error("dest");
   a_lit_wide_map: assert property (
      o_fetch |-> o_dec.lit_is_9 == (w_q[11:9] == 3'h5)) else $error("lit9");
   a_phase_at_fetch: assert property (
      o_fetch |-> o_phase == 2'h3) else $error("phase not three at load");
   a_skip_second: assert property (
      o_fetch && o_dec.cond_skip ##3 i_skip_true |=> o_second_cycle)
      else $error("true skip did not add a cycle");
   c_two: cover property (o_fetch && o_dec.two_cycle);
   c_skip: cover property (o_fetch && o_dec.cond_skip ##[1:8] o_second_cycle);
   c_bit: cover property (o_fetch && o_dec.class_sel == TBD_CLS_BIT);
endmodule

// ---- tbd_prog_mem.sv ----
// program memory model, one word per fetch
// assumes the bench fills mem before reset release
`timescale 1ns/1ps
module tbd_prog_mem (
   // clock and fetch
   input  wire logic   i_ref_clk,
   input  wire logic   i_fetch,
   // instruction word
   output logic [11:0] o_word
);
   logic [11:0] mem [256];
   int          ptr_q = 0;
   always @(posedge i_ref_clk) if (i_fetch === 1'b1) ptr_q <= ptr_q + 1;
   assign o_word = mem[ptr_q];
endmodule

// ---- tbd_decoder_tb.sv ----
// self-checking bench for the instruction decoder
// assumes the program memory model and the checker
`timescale 1ns/1ps
module tbd_decoder_tb;
   import tbd_pkg::*;
   logic           i_ref_clk;
   logic           i_arst_n;
   logic           i_skip_true;
   logic [11:0]    i_instr;
   tbd_decode_type o_dec;
   tbd_decode_type e;
   logic           o_fetch;
   logic           o_second_cycle;
   logic [1:0]     o_phase;
   logic           s;
   int             err_total = 0;
   int             checks = 0;
   int             n, t, g, sc;
   logic [11:0]    dir [12] = '{12'ha55, 12'h9ff, 12'h8aa, 12'h6e3, 12'h7ff,
      12'h2df, 12'h3c1, 12'h1c0, 12'h1ff, 12'h4ab, 12'he5a, 12'h006};
   initial begin
      i_ref_clk = 1'b0;
      forever #5 i_ref_clk = ~i_ref_clk;
   end
   tbd_prog_mem i_tbd_prog_mem (.i_ref_clk(i_ref_clk), .i_fetch(o_fetch),
      .o_word(i_instr));
   tbd_decoder i_tbd_decoder (.i_ref_clk(i_ref_clk), .i_arst_n(i_arst_n),
      .i_instr(i_instr), .i_skip_true(i_skip_true), .o_dec(o_dec),
      .o_fetch(o_fetch), .o_second_cycle(o_second_cycle), .o_phase(o_phase));
   task check(input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         err_total++;
         $display("unexpected at %0t: %h vs %h", $time, seen, exp);
      end
   endtask
   task finish_test;
      if (err_total == 0 && checks > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   function automatic tbd_decode_type cut(input tbd_decode_type d);
      if (d.class_sel != TBD_CLS_BYTE) d.dest_file = 1'b0;
      if (d.class_sel != TBD_CLS_BIT) d.bit_sel = 3'h0;
      if (d.class_sel != TBD_CLS_LIT) d.literal = 9'h0;
      return d;
   endfunction
   function automatic tbd_decode_type model(input logic [11:0] w);
      tbd_decode_type d;
      d = '0;
      d.class_sel = w[11] ? TBD_CLS_LIT : w[10] ? TBD_CLS_BIT : TBD_CLS_BYTE;
      d.lit_is_9 = w[11:9] == 3'h5;
      d.opcode = !w[11] && !w[10] ? w[11:6] :
         d.lit_is_9 ? {3'h0, w[11:9]} : {2'h0, w[11:8]};
      d.dest_file = w[5];
      d.file_sel = w[11] ? 5'h0 : w[4:0];
      d.bit_sel = w[7:5];
      d.literal = d.lit_is_9 ? w[8:0] : {1'b0, w[7:0]};
      d.two_cycle = d.lit_is_9 || w[11:9] == 3'h4;
      d.cond_skip = w[11:9] == 3'h3 || w[11:6] == 6'h0b || w[11:6] == 6'h0f;
      return cut(d);
   endfunction
   initial begin
      i_arst_n = 1'b0;
      i_skip_true = 1'b0;
      s = 1'b0;
      g = 0;
      void'($urandom(32'hbe52));
      for (int i = 0; i < 256; i++) i_tbd_prog_mem.mem[i] = 12'($urandom);
      foreach (dir[i]) i_tbd_prog_mem.mem[i] = dir[i];
      repeat (9) @(posedge i_ref_clk);
      #1;
      check(32'({o_fetch, o_second_cycle, o_phase}), 32'h0);
      check(32'(o_dec), 32'h0);
      @(posedge i_ref_clk);
      i_arst_n <= 1'b1;
      for (n = 0; n < 200; n++) begin
         t = 0;
         sc = 0;
         do begin
            @(posedge i_ref_clk);
            i_skip_true <= s;
            #1;
            t++;
            if (o_second_cycle === 1'b1) sc++;
         end while (o_fetch !== 1'b1 && t < 20);
         if (o_fetch !== 1'b1) begin
            err_total++;
            n = 200;
         end else begin
            check(t, (n > 0) ? g : 4);
            check(sc, (g == 8) ? 4 : 0);
            check(32'(o_phase), 32'h3);
            e = model(i_tbd_prog_mem.mem[n]);
            check(32'(cut(o_dec)), 32'(e));
            s = 1'($urandom);
            g = (e.two_cycle || (e.cond_skip && s)) ? 8 : 4;
         end
      end
      finish_test;
   end
endmodule
bind tbd_decoder tbd_decoder_sva i_tbd_decoder_sva (.i_ref_clk(i_ref_clk),
   .i_arst_n(i_arst_n), .i_instr(i_instr), .i_skip_true(i_skip_true),
   .o_dec(o_dec), .o_fetch(o_fetch), .o_second_cycle(o_second_cycle),
   .o_phase(o_phase));
